// >>> include/hsz_pkg.sv
// What this block does
// R1 - shift travel past upper or lower limit raises major error 1102 or 1103, no completion
// R2 - shift travel runs at home-return speed or creep speed, chosen per axis
// R3 - shift speed selector: 0 home-return speed, 1 creep speed, default 0
// R4 - dog travel and shift amount are signed 32-bit position values
// R5 - shift applies to dog, count, cradle, limit, scale, dogless; not data-set, stopper, driver
// R6 - monitor values and status flags update only after shift travel ends
// R7 - home return completes only once the zero-pass flag is high
// R8 - home condition 1 sets zero-pass flag at amplifier power-up without a mark pass
// R9 - home condition: 0 needs mark pass, 1 waives it, default 0
// R10 - new home condition takes effect only after amplifier power cycle
// R11 - scale-signal return with home condition 1 gives minor error 124, no return
// R12 - zero-return command names exactly one axis; matching axis runs configured method
// R13 - at shift end, stop axis and load home address into current position
//
// Purpose: constants shared by the home shift / zero pass block
// Assumes: one axis per instance, 32-bit register port
// Notes: byte addresses, one 32-bit word per register
package hsz_pkg;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_SHIFT = 8'h08;
    localparam logic [7:0] OFS_DOG = 8'h0C;
    localparam logic [7:0] OFS_HADDR = 8'h10;
    localparam logic [7:0] OFS_RSPD = 8'h14;
    localparam logic [7:0] OFS_CSPD = 8'h18;
    localparam logic [7:0] OFS_STAT = 8'h1C;
    localparam logic [7:0] OFS_ERR = 8'h20;
    localparam logic [7:0] OFS_POS = 8'h24;
    localparam logic [7:0] OFS_MON = 8'h28;
    localparam logic [7:0] OFS_ISTAT = 8'h2C;
    localparam logic [7:0] OFS_IMASK = 8'h30;
    // ctrl field positions
    localparam int CTRL_METHOD_LSB = 0;
    localparam int CTRL_SPDSEL = 4;
    localparam int CTRL_HCOND = 5;
    localparam int CTRL_DIR = 6;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // command: bit 8 start, bits 4:0 axis number
    localparam int CMD_GO = 8;
    // interrupt bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_MAJOR = 1;
    localparam int IRQ_MINOR = 2;
    localparam logic [15:0] ERR_UPPER = 16'd1102;
    localparam logic [15:0] ERR_LOWER = 16'd1103;
    localparam logic [15:0] ERR_SCALE = 16'd124;
    localparam logic [3:0] M_DOG = 4'h0;
    localparam logic [3:0] M_COUNT = 4'h1;
    localparam logic [3:0] M_DATASET = 4'h2;
    localparam logic [3:0] M_CRADLE = 4'h3;
    localparam logic [3:0] M_STOPPER = 4'h4;
    localparam logic [3:0] M_LIMIT = 4'h5;
    localparam logic [3:0] M_SCALE = 4'h6;
    localparam logic [3:0] M_DOGLESS = 4'h7;
    localparam logic [3:0] M_DRIVER = 4'h8;
    typedef enum logic [2:0] {ST_IDLE, ST_SEEK, ST_SHIFT, ST_FIX} hsz_state_e;
endpackage

// >>> include/hsz_move_if.sv
`timescale 1ns/1ps
// Purpose: carries one shift travel request and its progress
// Assumes: single clock domain
// Notes: step is the signed travel of the current cycle
interface hsz_move_if;
    logic start;
    logic signed [31:0] amount;
    logic [31:0] speed;
    logic busy;
    logic done;
    logic signed [31:0] step;
    modport ctl(output start, output amount, output speed, input busy, input done, input step);
    modport mover(input start, input amount, input speed, output busy, output done, output step);
endinterface

// >>> logic/hsz_shift_mover.sv
`timescale 1ns/1ps
// Purpose: walks the axis through a signed shift amount at a given speed
// Assumes: speed is in position units per cycle
// Notes: a speed of zero is treated as one so the travel always ends
module hsz_shift_mover (
    input wire logic mclk_in,
    input wire logic reset_in,
    hsz_move_if.mover mv
);
    logic [31:0] remain;
    logic neg;
    logic [31:0] eff;
    logic [31:0] mag;

    // per-cycle magnitude, never more than what is left
    always_comb begin
        eff = (mv.speed == 32'h0000_0000) ? 32'h0000_0001 : mv.speed;
        mag = (eff > remain) ? remain : eff;
        mv.step = neg ? -$signed(mag) : $signed(mag);
        if (!mv.busy) begin
            mv.step = 32'sh0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // remaining distance
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            remain <= 32'h0000_0000;
            neg <= 1'b0;
            mv.busy <= 1'b0;
            mv.done <= 1'b0;
        end else begin
            mv.done <= 1'b0;
            if (mv.start) begin
                neg <= mv.amount[31];
                remain <= mv.amount[31] ? 32'(-mv.amount) : 32'(mv.amount);
                mv.busy <= (mv.amount != 32'sh0000_0000);
                mv.done <= (mv.amount == 32'sh0000_0000);
            end else if (mv.busy) begin
                remain <= remain - mag;
                if (remain == mag) begin
                    mv.busy <= 1'b0;
                    mv.done <= 1'b1;
                end
            end
        end
    end
endmodule

// >>> logic/hsz_zero_pass.sv
`timescale 1ns/1ps
// Purpose: zero-pass flag of one axis
// Assumes: amp_on is a level, z_phase a one-cycle marker pulse
// Notes: home condition is captured at amplifier power-up only
module hsz_zero_pass (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic amp_on_in,
    input wire logic z_phase_in,
    input wire logic cond_in,
    output logic cond_out,
    output logic zero_pass_flag_out
);
    logic amp_prev;
    logic amp_rise;

    assign amp_rise = amp_on_in && !amp_prev;

    // latch condition at power-up so edits wait for a power cycle [R10]
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            amp_prev <= 1'b0;
            cond_out <= 1'b0;
        end else begin
            amp_prev <= amp_on_in;
            if (amp_rise) begin
                cond_out <= cond_in; // [R9] [R10]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // flag: set by mark pass, or at power-up when waived
    always_ff @(posedge mclk_in) begin
        if (reset_in || !amp_on_in) begin
            zero_pass_flag_out <= 1'b0;
        end else if (amp_rise && cond_in) begin
            zero_pass_flag_out <= 1'b1; // [R8]
        end else if (z_phase_in && !amp_rise) begin
            zero_pass_flag_out <= 1'b1; // [R7]
        end
    end
endmodule

// >>> logic/hsz_home_ctrl.sv
`timescale 1ns/1ps
// Purpose: home return sequencing with home shift and zero-pass gating
// Assumes: the method logic outside pulses zero_detect_in when its zero is found
// Notes: one instance per axis; registers on a plain strobe port
module hsz_home_ctrl
    import hsz_pkg::*;
#(
    parameter int AXIS_ID = 0
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic zero_detect_in,
    input wire logic z_phase_in,
    input wire logic amp_on_in,
    input wire logic upper_limit_switch_in,
    input wire logic lower_limit_switch_in,
    output logic signed [31:0] speed_out,
    output logic moving_out,
    output logic signed [31:0] cur_pos_out,
    output logic home_done_out,
    output logic zero_pass_flag_out,
    output logic irq_out
);
    generate
        if (AXIS_ID < 0 || AXIS_ID > 31) begin : g_bad_axis
            $error("AXIS_ID must be 0 to 31");
        end
    endgenerate

    hsz_state_e state;
    logic [31:0] ctrl;
    logic signed [31:0] shift_amt;
    logic signed [31:0] dog_travel;
    logic signed [31:0] home_addr;
    logic [31:0] ret_speed;
    logic [31:0] creep_speed;
    logic [15:0] major_code;
    logic [15:0] minor_code;
    logic signed [31:0] mon_pos;
    logic [2:0] int_stat;
    logic [2:0] int_mask;
    logic [2:0] ev;
    logic cond_live;
    logic go;
    logic shift_applies;
    logic hit_upper;
    logic hit_lower;
    logic [3:0] method;
    logic signed [31:0] seek_step;
    hsz_move_if mv();

    assign method = ctrl[CTRL_METHOD_LSB +: 4];

    ////////////////////////////////////////////////////////////////////
    // submodules
    // an aborted shift is not cancelled in the mover: it drains on its own while
    // speed_out already reads zero, and the next start simply reloads it
    hsz_shift_mover u_mover (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .mv(mv)
    );

    hsz_zero_pass u_zp (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .amp_on_in(amp_on_in),
        .z_phase_in(z_phase_in),
        .cond_in(ctrl[CTRL_HCOND]),
        .cond_out(cond_live),
        .zero_pass_flag_out(zero_pass_flag_out)
    );

    ////////////////////////////////////////////////////////////////////
    // decode helpers
    // a start counts only when the command names this axis [R12]
    assign go = wr_in && (addr_in == OFS_CMD) && wdata_in[CMD_GO]
        && (wdata_in[4:0] == 5'(AXIS_ID));

    // methods whose home point is moved by the shift amount [R5]
    always_comb begin
        shift_applies = 1'b0;
        if (method == M_DOG || method == M_COUNT || method == M_CRADLE) begin
            shift_applies = 1'b1;
        end else if (method == M_LIMIT || method == M_SCALE || method == M_DOGLESS) begin
            shift_applies = 1'b1;
        end
    end

    // limit hits only count in the direction of shift travel [R1]
    assign hit_upper = upper_limit_switch_in && (mv.step > 32'sh0000_0000);
    assign hit_lower = lower_limit_switch_in && (mv.step < 32'sh0000_0000);

    assign seek_step = ctrl[CTRL_DIR] ? -$signed(ret_speed) : $signed(ret_speed);

    // shift request to the mover
    assign mv.start = (state == ST_SEEK) && zero_detect_in && shift_applies;
    assign mv.amount = shift_amt; // [R4]
    // creep when selector is 1, home-return speed when 0 [R2] [R3]
    assign mv.speed = ctrl[CTRL_SPDSEL] ? creep_speed : ret_speed;

    ////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (go && !(method == M_SCALE && cond_live)) begin // [R11]
                        state <= ST_SEEK;
                    end
                end
                ST_SEEK: begin
                    if (zero_detect_in) begin
                        state <= shift_applies ? ST_SHIFT : ST_FIX; // [R5]
                    end
                end
                ST_SHIFT: begin
                    if (hit_upper || hit_lower) begin
                        state <= ST_IDLE; // [R1]
                    end else if (mv.done) begin
                        state <= ST_FIX;
                    end
                end
                ST_FIX: begin
                    if (zero_pass_flag_out) begin
                        state <= ST_IDLE; // [R7]
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // motion command: seek speed, then shift steps, stopped elsewhere
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            speed_out <= 32'sh0000_0000;
            moving_out <= 1'b0;
        end else if (state == ST_SEEK && !zero_detect_in) begin
            speed_out <= seek_step;
            moving_out <= 1'b1;
        end else if (state == ST_SHIFT && !hit_upper && !hit_lower && mv.busy) begin
            speed_out <= mv.step;
            moving_out <= 1'b1;
        end else begin
            speed_out <= 32'sh0000_0000; // [R13]
            moving_out <= 1'b0;
        end
    end

    // current position integrates the travel; fixed to home address at the end
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            cur_pos_out <= 32'sh0000_0000;
        end else if (state == ST_FIX && zero_pass_flag_out) begin
            cur_pos_out <= home_addr; // [R13]
        end else if (moving_out) begin
            cur_pos_out <= cur_pos_out + speed_out;
        end
    end

    // monitor and done flag only set once the shift has ended; done clears on a new start [R6]
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            mon_pos <= 32'sh0000_0000;
            home_done_out <= 1'b0;
        end else if (state == ST_FIX && zero_pass_flag_out) begin
            mon_pos <= home_addr; // [R6]
            home_done_out <= 1'b1;
        end else if (go) begin
            home_done_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // error codes: last one wins, kept until reset
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            major_code <= 16'h0000;
            minor_code <= 16'h0000;
        end else if (state == ST_SHIFT && hit_upper) begin
            major_code <= ERR_UPPER; // [R1]
        end else if (state == ST_SHIFT && hit_lower) begin
            major_code <= ERR_LOWER; // [R1]
        end else if (state == ST_IDLE && go && method == M_SCALE && cond_live) begin
            minor_code <= ERR_SCALE; // [R11]
        end
    end

    // events feeding the sticky status
    assign ev[IRQ_DONE] = (state == ST_FIX) && zero_pass_flag_out;
    assign ev[IRQ_MAJOR] = (state == ST_SHIFT) && (hit_upper || hit_lower);
    assign ev[IRQ_MINOR] = (state == ST_IDLE) && go && (method == M_SCALE) && cond_live;

    // write-one-to-clear; a new event in the clearing cycle stays set
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            int_stat <= 3'h0;
        end else if (wr_in && addr_in == OFS_ISTAT) begin
            int_stat <= (int_stat & ~wdata_in[2:0]) | ev;
        end else begin
            int_stat <= int_stat | ev;
        end
    end

    assign irq_out = |(int_stat & int_mask);

    ////////////////////////////////////////////////////////////////////
    // register writes; parameters only change while idle, the interrupt mask at any time
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            ctrl <= CTRL_RESET; // [R3] [R9]
            shift_amt <= 32'sh0000_0000;
            dog_travel <= 32'sh0000_0000;
            home_addr <= 32'sh0000_0000;
            ret_speed <= 32'h0000_0001;
            creep_speed <= 32'h0000_0001;
            int_mask <= 3'h0;
        end else if (wr_in) begin
            if (addr_in == OFS_CTRL && state == ST_IDLE) begin
                ctrl <= {25'h0, wdata_in[6:0]};
            end else if (addr_in == OFS_SHIFT && state == ST_IDLE) begin
                shift_amt <= wdata_in; // [R4]
            end else if (addr_in == OFS_DOG && state == ST_IDLE) begin
                dog_travel <= wdata_in; // [R4]
            end else if (addr_in == OFS_HADDR && state == ST_IDLE) begin
                home_addr <= wdata_in;
            end else if (addr_in == OFS_RSPD && state == ST_IDLE) begin
                ret_speed <= wdata_in;
            end else if (addr_in == OFS_CSPD && state == ST_IDLE) begin
                creep_speed <= wdata_in;
            end else if (addr_in == OFS_IMASK) begin
                int_mask <= wdata_in[2:0];
            end
        end
    end

    // read data one cycle after the strobe, zero otherwise and when unmapped
    always_ff @(posedge mclk_in) begin
        if (reset_in || !rd_in) begin
            rdata_out <= 32'h0000_0000;
        end else if (addr_in == OFS_CTRL) begin
            rdata_out <= ctrl;
        end else if (addr_in == OFS_SHIFT) begin
            rdata_out <= shift_amt;
        end else if (addr_in == OFS_DOG) begin
            rdata_out <= dog_travel;
        end else if (addr_in == OFS_HADDR) begin
            rdata_out <= home_addr;
        end else if (addr_in == OFS_RSPD) begin
            rdata_out <= ret_speed;
        end else if (addr_in == OFS_CSPD) begin
            rdata_out <= creep_speed;
        end else if (addr_in == OFS_STAT) begin
            rdata_out <= {24'h0, cond_live, zero_pass_flag_out, home_done_out, 2'h0, 3'(state)};
        end else if (addr_in == OFS_ERR) begin
            rdata_out <= {major_code, minor_code};
        end else if (addr_in == OFS_POS) begin
            rdata_out <= cur_pos_out;
        end else if (addr_in == OFS_MON) begin
            rdata_out <= mon_pos;
        end else if (addr_in == OFS_ISTAT) begin
            rdata_out <= {29'h0, int_stat};
        end else if (addr_in == OFS_IMASK) begin
            rdata_out <= {29'h0, int_mask};
        end else begin
            rdata_out <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    a_limit_upper_code: assert property ( // [R1]
        state == ST_SHIFT && hit_upper |=> major_code == ERR_UPPER && state == ST_IDLE
        && !home_done_out)
        else $error("upper limit during shift did not give 1102");
    a_limit_lower_code: assert property ( // [R1]
        state == ST_SHIFT && hit_lower && !hit_upper |=> major_code == ERR_LOWER)
        else $error("lower limit during shift did not give 1103");
    // every shift step but the last one runs at the full selected speed, when that speed is not zero
    a_shift_speed_sel: assert property ( // [R2]
        moving_out && $past(state) == ST_SHIFT && !mv.done && mv.speed != 32'h0000_0000
        |-> speed_out == $signed(ctrl[CTRL_SPDSEL] ? creep_speed : ret_speed)
        || speed_out == -$signed(ctrl[CTRL_SPDSEL] ? creep_speed : ret_speed))
        else $error("shift speed does not follow selector");
    a_ctrl_reset_zero: assert property ( // [R3]
        $fell(reset_in) |-> ctrl[CTRL_SPDSEL] == 1'b0 && ctrl[CTRL_HCOND] == 1'b0)
        else $error("selectors not zero after reset");
    a_no_shift_methods: assert property ( // [R5]
        state == ST_SEEK && zero_detect_in && !shift_applies |=> state == ST_FIX)
        else $error("non-shift method entered shift travel");
    a_monitor_after_shift: assert property ( // [R6]
        $changed(mon_pos) |-> $past(state) == ST_FIX)
        else $error("monitor changed before shift end");
    a_done_needs_zp: assert property ( // [R7]
        $rose(home_done_out) |-> $past(zero_pass_flag_out))
        else $error("home done without zero-pass flag");
    a_scale_refused: assert property ( // [R11]
        state == ST_IDLE && go && method == M_SCALE && cond_live
        |=> state == ST_IDLE && minor_code == ERR_SCALE)
        else $error("scale return not refused with condition 1");
    a_axis_match: assert property ( // [R12]
        state == ST_IDLE && wr_in && addr_in == OFS_CMD && wdata_in[4:0] != 5'(AXIS_ID)
        |=> state == ST_IDLE)
        else $error("command for another axis started this one");
    a_home_load: assert property ( // [R13]
        state == ST_FIX && zero_pass_flag_out |=> cur_pos_out == $past(home_addr)
        && !moving_out && home_done_out)
        else $error("home address not loaded at completion");
    a_monitor_load: assert property ( // [R6]
        state == ST_FIX && zero_pass_flag_out |=> mon_pos == $past(home_addr))
        else $error("monitor not loaded at shift end");
    a_start_seek: assert property ( // [R12]
        state == ST_IDLE && go && !(method == M_SCALE && cond_live) |=> state == ST_SEEK)
        else $error("start for this axis did not begin the seek");
    a_zp_waived: assert property ( // [R8]
        $rose(amp_on_in) && ctrl[CTRL_HCOND] |=> zero_pass_flag_out)
        else $error("waived condition did not set zero-pass flag at power-up");
    // a power cycle clears the zero-pass flag, so condition 0 asks for a fresh mark pass
    a_zp_power_off: assert property ( // [R9]
        !amp_on_in |=> !zero_pass_flag_out)
        else $error("zero-pass flag held with amplifier off");


    c_shift_done: cover property (state == ST_SHIFT ##[1:50] state == ST_FIX);
    c_upper_err: cover property (state == ST_SHIFT && hit_upper);
    c_scale_err: cover property (ev[IRQ_MINOR]);
    c_home_done: cover property ($rose(home_done_out));
    c_neg_seek: cover property (state == ST_SEEK && moving_out && speed_out < 0);
endmodule

// >>> verification/hsz_amp_model.sv
`timescale 1ns/1ps
// Purpose: amplifier, encoder and limit switch stand-in for one axis
// Assumes: the axis stands where the controller commands it
// Notes: switches sit at +/-LIMIT; the mark is a pulse as long as its request
module hsz_amp_model #(
    parameter int LIMIT = 200
) (
    input wire logic power_in,
    input wire logic z_req_in,
    input wire logic signed [31:0] pos_in,
    output logic amp_on_out,
    output logic z_phase_out,
    output logic upper_limit_switch_out,
    output logic lower_limit_switch_out
);
    // power follows the operator switch; toggling it applies a new home condition
    assign amp_on_out = power_in;
    // an unpowered encoder gives no mark
    assign z_phase_out = z_req_in & power_in;
    // switch levels come from where the axis stands, so no travel model is needed
    assign upper_limit_switch_out = (pos_in >= LIMIT);
    assign lower_limit_switch_out = (pos_in <= -LIMIT);
endmodule

// >>> verification/hsz_tb_top.sv
`timescale 1ns/1ps
// Purpose: register-level tests of home shift and zero pass control
// Assumes: axis number 3, speeds 8 and 4, limits at +/-200
// Notes: home address changes per return so stale monitor values show
module home_shift_and_zero_pass_control_tb_top;
    import hsz_pkg::*;
    logic mclk_in, reset_in, wr, rd, zd, power, z_req, zph, amp, ul, ll;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, d;
    logic signed [31:0] speed, pos;
    logic moving, done, flag, irq;
    int n_mismatch = 0;
    int n_tests = 0;
    int prev;
    int i;
    hsz_home_ctrl #(.AXIS_ID(3)) i_hsz_home_ctrl (.mclk_in(mclk_in), .reset_in(reset_in),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .zero_detect_in(zd), .z_phase_in(zph), .amp_on_in(amp), .upper_limit_switch_in(ul),
        .lower_limit_switch_in(ll), .speed_out(speed), .moving_out(moving),
        .cur_pos_out(pos), .home_done_out(done), .zero_pass_flag_out(flag), .irq_out(irq));
    hsz_amp_model #(.LIMIT(200)) i_hsz_amp_model (.power_in(power), .z_req_in(z_req),
        .pos_in(pos), .amp_on_out(amp), .z_phase_out(zph), .upper_limit_switch_out(ul),
        .lower_limit_switch_out(ll));
    // 50 MHz clock
    always #10 mclk_in = ~mclk_in;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask
    // one-cycle write strobe
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk_in);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk_in);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk_in);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask
    // start a return and report the zero signal three cycles after the seek motion starts
    task automatic go(input logic [6:0] m, input bit sel, input int sh, input int ha);
        wr_reg(OFS_CTRL, 32'(m) | (32'(sel) << CTRL_SPDSEL));
        wr_reg(OFS_SHIFT, sh);
        wr_reg(OFS_HADDR, ha);
        wr_reg(OFS_CMD, 32'h0000_0103);
        for (i = 0; i < 10 && moving !== 1'b1; i++) tick(1);
        chk("seek", m[CTRL_DIR] ? -8 : 8, speed);
        tick(2);
        @(posedge mclk_in);
        zd <= 1'b1;
        @(posedge mclk_in);
        zd <= 1'b0;
        tick(2);
    endtask
    task automatic wait_done();
        for (i = 0; i < 400 && done !== 1'b1; i++) tick(1);
    endtask
    task automatic wait_stop();
        for (i = 0; i < 400 && moving !== 1'b0; i++) tick(1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // watchdog: whole run is a few hundred cycles
    initial begin
        #400000;
        n_mismatch++;
        results();
    end
    initial begin
        {mclk_in, wr, rd, zd, power, z_req} = '0;
        reset_in = 1'b1;
        addr = 8'h00;
        wdata = 32'h0;
        repeat (20) @(posedge mclk_in);
        reset_in <= 1'b0;
        rd_reg(OFS_CTRL, d); chk("ctrl", CTRL_RESET, d);
        rd_reg(8'hFC, d); chk("unmapped", 32'h0, d);
        wr_reg(OFS_STAT, 32'hFFFF_FFFF);
        rd_reg(OFS_STAT, d); chk("stat", 32'h0, d);
        wr_reg(OFS_RSPD, 8);
        wr_reg(OFS_CSPD, 4);
        wr_reg(OFS_IMASK, 32'h1);
        wr_reg(OFS_DOG, 32'h8000_0000);
        wr_reg(OFS_SHIFT, 32'h7FFF_FFFF);
        rd_reg(OFS_DOG, d); chk("dog", 32'h8000_0000, d);
        rd_reg(OFS_SHIFT, d); chk("shift", 32'h7FFF_FFFF, d);
        power <= 1'b1;
        tick(3); chk("flag", 0, flag);
        // command naming another axis is ignored
        wr_reg(OFS_CMD, 32'h0000_0104);
        rd_reg(OFS_STAT, d); chk("state", 0, d[2:0]);
        // no mark passed yet: the return parks before completion
        go(M_DOG, 1'b0, 40, 16);
        tick(20); chk("done", 0, done);
        @(posedge mclk_in);
        z_req <= 1'b1;
        @(posedge mclk_in);
        z_req <= 1'b0;
        wait_done(); chk("done", 1, done);
        chk("irq", 1, irq);
        wr_reg(OFS_IMASK, 32'h0);
        tick(1); chk("irq", 0, irq);
        wr_reg(OFS_ISTAT, 32'h7);
        wr_reg(OFS_IMASK, 32'h1);
        tick(1); chk("irq", 0, irq);
        prev = 16;
        // every method, scale too while the mark pass is still required;
        // speed selector alternates with the method number
        for (int m = 0; m < 9; m++) begin
            automatic bit sh = !(m inside {M_DATASET, M_STOPPER, M_DRIVER});
            go(7'(m), m[0], 40, m * 8 + 8);
            chk("done", !sh, done);
            if (sh) begin
                chk("speed", m[0] ? 4 : 8, speed);
                rd_reg(OFS_MON, d); chk("mon", prev, d);
            end
            wait_done();
            chk("pos", m * 8 + 8, pos);
            rd_reg(OFS_MON, d); chk("mon", m * 8 + 8, d);
            prev = m * 8 + 8;
        end
        // shift beyond either limit switch
        go(M_DOG, 1'b0, 1000, 0);
        wait_stop(); rd_reg(OFS_ERR, d); chk("major", ERR_UPPER, d[31:16]);
        chk("done", 0, done);
        go(7'(M_DOG) | 7'(1 << CTRL_DIR), 1'b0, -1000, 0);
        wait_stop(); rd_reg(OFS_ERR, d); chk("major", ERR_LOWER, d[31:16]);
        chk("done", 0, done);
        // waive the mark pass, then power cycle the amplifier
        wr_reg(OFS_CTRL, 32'(M_SCALE) | (32'h1 << CTRL_HCOND));
        rd_reg(OFS_STAT, d); chk("cond", 0, d[7]);
        power <= 1'b0;
        tick(3); chk("flag", 0, flag);
        power <= 1'b1;
        tick(3); chk("flag", 1, flag);
        rd_reg(OFS_STAT, d); chk("cond", 1, d[7]);
        wr_reg(OFS_CMD, 32'h0000_0103);
        rd_reg(OFS_ERR, d); chk("minor", ERR_SCALE, d[15:0]);
        rd_reg(OFS_STAT, d); chk("state", 0, d[2:0]);
        results();
    end
endmodule
